/* File: bench/idle_stop_power_mode_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module idle_stop_power_mode_control_tb_top;
  import ispmc_pkg::*;
  localparam logic [11:0] CF = ISPMC_CFG_OFS;
  localparam logic [7:0] PW = ISPMC_PWR_CTRL_ADDR;
  localparam logic [7:0] WK = ISPMC_WAKE_FLAGS_ADDR;
  localparam int HB = ISPMC_STAT_HALT_BIT;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq = 1'b0;
  logic erst = 1'b0;
  logic mcd = 1'b0;
  logic cs_ev = 1'b0;
  logic sreq = 1'b0;
  logic lpreq = 1'b0;
  logic susp, lp_run, posc, pclk, lowp;
  logic [1:0] mode;
  logic [31:0] rd, v;
  logic se;
  int err_total = 0;
  int checks_done = 0;
  int n, k;
  ispmc_if link_if (.ref_clk_i(ref_clk_i));
  ispmc_dev_end u_ispmc_dev_end (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .link(link_if), .cs_event_i(cs_ev), .suspend_req_i(sreq),
    .lp_osc_req_i(lpreq), .suspend_o(susp), .lp_osc_run_o(lp_run),
    .prec_osc_en_o(posc), .periph_clk_en_o(pclk), .low_power_o(lowp),
    .mode_o(mode));
  // short watchdog count keeps the run brief
  ispmc_core_end #(.WDT_CLKS(16)) u_ispmc_core_end (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .link(link_if), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_i(irq), .ext_rst_i(erst),
    .mcd_fault_i(mcd));
  ispmc_checker u_ispmc_checker (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .sfr_addr(link_if.sfr_addr), .sfr_wdata(link_if.sfr_wdata),
    .sfr_wr(link_if.sfr_wr), .instr_done(link_if.instr_done),
    .int_pend(link_if.int_pend), .wdt_expire(link_if.wdt_expire),
    .mcd_expire(link_if.mcd_expire), .ext_rst(link_if.ext_rst),
    .core_halt(link_if.core_halt), .int_service(link_if.int_service),
    .core_rst(link_if.core_rst), .fetch_addr(link_if.fetch_addr));
  // 10 mhz clock
  initial
  begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer; data sampled at the edge pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1)
      @(posedge ref_clk_i);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // status polling is bounded so a stuck flag shows as a mismatch
  task poll(input int b, input logic val);
    apb(1'b0, ISPMC_STAT_OFS, 32'h0);
    for (n = 0; n < 100 && rd[b] !== val; n++)
      apb(1'b0, ISPMC_STAT_OFS, 32'h0);
  endtask
  // a link access also kicks the watchdog, so it never fires mid-command
  task sfr(input logic r, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, ISPMC_CMD_OFS, (32'h1 << ISPMC_CMD_GO_BIT) |
      (32'h1 << ISPMC_CMD_KICK_BIT) | 32'({r, d, a}));
    poll(ISPMC_STAT_BUSY_BIT, 1'b0);
  endtask
  initial
  begin
    #2000000;
    err_total++;
    report_and_stop;
  end
  initial
  begin
    void'($urandom(32'h0623));
    repeat (5) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    v = $urandom;
    apb(1'b0, CF, 32'h0);
    chk(rd, 32'(ISPMC_CFG_RST));
    apb(1'b1, CF, v);
    apb(1'b0, CF, 32'h0);
    chk(rd, {28'h0, v[3:0]});
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, se}, 32'h1);
    // interrupts on, watchdog off so idle may last
    apb(1'b1, CF, 32'h8);
    repeat (10) @(posedge ref_clk_i);
    sfr(1'b0, PW, {v[7:2], 2'h1});
    poll(HB, 1'b1);
    chk(32'(mode), 32'(ISPMC_MODE_IDLE));
    chk({31'h0, pclk}, 32'h1);
    chk({31'h0, lowp}, 32'h1);
    repeat (40) @(posedge ref_clk_i);
    chk(32'(mode), 32'(ISPMC_MODE_IDLE));
    irq <= 1'b1;
    poll(HB, 1'b0);
    chk({31'h0, rd[HB]}, 32'h0);
    irq <= 1'b0;
    sfr(1'b1, PW, 8'h00);
    chk({24'h0, rd[7:0]}, 32'h0);
    // stop, left only by external reset, then by missing clock
    for (k = 0; k < 2; k++)
    begin
      lpreq <= k[0];
      apb(1'b1, CF, k ? 32'he : 32'h8);
      sfr(1'b0, PW, k ? 8'h03 : 8'h02);
      poll(HB, 1'b1);
      chk(32'(mode), 32'(ISPMC_MODE_STOP));
      chk({31'h0, posc}, 32'h0);
      chk({31'h0, lp_run}, {31'h0, k[0]});
      chk({31'h0, lowp}, {31'h0, !k[0]});
      irq <= 1'b1;
      repeat (20) @(posedge ref_clk_i);
      chk(32'(mode), 32'(ISPMC_MODE_STOP));
      irq <= 1'b0;
      mcd <= k[0];
      erst <= !k[0];
      repeat (2) @(posedge ref_clk_i);
      mcd <= 1'b0;
      erst <= 1'b0;
      poll(HB, 1'b0);
      chk({31'h0, rd[HB]}, 32'h0);
      sfr(1'b1, PW, 8'h00);
      chk({24'h0, rd[7:0]}, 32'h0);
    end
    lpreq <= 1'b0;
    apb(1'b1, CF, 32'h1);
    sfr(1'b0, PW, 8'h01);
    poll(HB, 1'b1);
    chk({31'h0, rd[HB]}, 32'h1);
    poll(HB, 1'b0);
    chk({31'h0, rd[HB]}, 32'h0);
    apb(1'b1, CF, 32'h8);
    // wake flag: enable, suspend, wake by sense event
    sfr(1'b0, WK, {v[15:9], 1'b1});
    sreq <= 1'b1;
    for (n = 0; n < 20 && susp !== 1'b1; n++)
      @(posedge ref_clk_i);
    chk({31'h0, susp}, 32'h1);
    // wake lands on the edge the read command is taken, a cycle before the device latches it; the settle window keeps flags at 0
    fork
      sfr(1'b1, WK, 8'h00);
      begin
        repeat (2) @(posedge ref_clk_i);
        cs_ev <= 1'b1;
        @(posedge ref_clk_i);
        cs_ev <= 1'b0;
      end
    join
    chk({24'h0, rd[7:0]}, 32'h0);
    chk({31'h0, susp}, 32'h0);
    chk({31'h0, lp_run}, 32'h1);
    sfr(1'b1, WK, 8'h00);
    chk({24'h0, rd[7:0]}, 32'h1);
    sfr(1'b0, WK, 8'h00);
    sfr(1'b1, WK, 8'h00);
    chk({24'h0, rd[7:0]}, 32'h0);
    sreq <= 1'b0;
    report_and_stop;
  end
endmodule // idle_stop_power_mode_control_tb_top
`default_nettype wire

/* File: bench/ispmc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ispmc_checker
  import ispmc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic instr_done,
  input wire logic int_pend,
  input wire logic wdt_expire,
  input wire logic mcd_expire,
  input wire logic ext_rst,
  input wire logic core_halt,
  input wire logic int_service,
  input wire logic core_rst,
  input wire logic [15:0] fetch_addr
);
  logic [1:0] pc_q;
  logic [1:0] pc_d;
  logic rs;
  // mirror of the mode bits; wake or reset clears them as the device does
  always_comb
  begin
    pc_d = pc_q;
    if (sfr_wr && sfr_addr == ISPMC_PWR_CTRL_ADDR)
      pc_d = sfr_wdata[1:0];
    if (int_service || core_rst)
      pc_d = 2'h0;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      pc_q <= 2'h0;
    else
      pc_q <= pc_d;
  end
  // any reset source, gated so mode checks skip reset hand-over
  assign rs = ext_rst | wdt_expire | mcd_expire;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  sequence rst_run_s;
    core_rst [*3];
  endsequence
  sequence woke_s;
    !core_halt && int_service;
  endsequence
  rst_seq_a: assert property ($fell(srst_i) |-> rst_run_s)
    else $error("reset sequence too short");
  rst_vec_a: assert property (fetch_addr == ISPMC_RESET_VECTOR)
    else $error("fetch address not the reset vector");
  rst_clear_a: assert property (core_rst |-> !core_halt)
    else $error("core halted during reset");
  mode_entry_a: assert property (instr_done && pc_q != 2'h0 && !core_rst
    && !rs |=> core_halt)
    else $error("no halt after mode bit write");
  idle_wake_a: assert property (core_halt && pc_q == 2'h1 && int_pend
    && !rs |=> woke_s)
    else $error("interrupt did not end idle");
  stop_hold_a: assert property (core_halt && pc_q[1] && !rs
    |=> core_halt && !int_service)
    else $error("stop left without reset");
  rst_exit_a: assert property (core_halt && rs |-> ##[1:2] core_rst)
    else $error("reset did not end low power");
  svc_src_a: assert property (int_service
    |-> $past(core_halt) && $past(int_pend))
    else $error("service pulse without wake");
endmodule // ispmc_checker
`default_nettype wire

/* File: rtl/ispmc_core_end.sv */
`timescale 1ns/1ps
`default_nettype none
module ispmc_core_end
  import ispmc_pkg::*;
#(
  parameter int WDT_CLKS = ISPMC_WDT_CLKS
)
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  ispmc_if.core link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_i,
  input wire logic ext_rst_i,
  input wire logic mcd_fault_i
);

  typedef struct packed {
    logic [3:0] cfg;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic busy;
    logic is_read;
    logic strobe;
    logic done;
    logic dropped;
    logic [31:0] wdt_cnt;
    logic wdt_exp;
  } ispmc_core_state_t;

  localparam ispmc_core_state_t CORE_RST = '{
    cfg: ISPMC_CFG_RST,
    addr: 8'h00,
    wdata: 8'h00,
    rdata: 8'h00,
    busy: 1'b0,
    is_read: 1'b0,
    strobe: 1'b0,
    done: 1'b0,
    dropped: 1'b0,
    wdt_cnt: 32'h0000_0000,
    wdt_exp: 1'b0
  };

  ispmc_core_state_t s_q;
  ispmc_core_state_t s_d;
  logic acc;
  logic wr_cmd;
  logic wr_cfg;
  logic mapped;

  assign acc = psel && penable;
  assign mapped = (paddr == ISPMC_CMD_OFS) || (paddr == ISPMC_STAT_OFS) ||
                  (paddr == ISPMC_CFG_OFS);
  assign wr_cmd = acc && pwrite && (paddr == ISPMC_CMD_OFS);
  assign wr_cfg = acc && pwrite && (paddr == ISPMC_CFG_OFS);

  // command sequencer and watchdog
  always_comb
  begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    s_d.done = 1'b0;
    s_d.wdt_exp = 1'b0;
    if (wr_cfg)
    begin
      s_d.cfg = pwdata[3:0];
    end
    // one-cycle strobe, then the instruction retires
    if (s_q.strobe)
    begin
      s_d.done = 1'b1;
    end
    // the device latches read data on the strobe edge, so take it a cycle
    // later; busy holds until then so status never shows stale data
    if (s_q.done)
    begin
      s_d.busy = 1'b0;
      if (s_q.is_read)
      begin
        s_d.rdata = link.sfr_rdata;
      end
    end
    if (wr_cmd && pwdata[ISPMC_CMD_GO_BIT])
    begin
      // a halted or resetting core cannot run an access
      if (s_q.busy || link.core_halt || link.core_rst)
      begin
        s_d.dropped = 1'b1;
      end
      else
      begin
        s_d.dropped = 1'b0;
        s_d.busy = 1'b1;
        s_d.strobe = 1'b1;
        s_d.addr = pwdata[ISPMC_CMD_ADDR_LSB +: 8];
        s_d.wdata = pwdata[ISPMC_CMD_DATA_LSB +: 8];
        s_d.is_read = pwdata[ISPMC_CMD_READ_BIT];
      end
    end
    // watchdog counts only while enabled; kick restarts it
    if (!s_q.cfg[ISPMC_CFG_WDT_BIT] || link.core_rst ||
        (wr_cmd && pwdata[ISPMC_CMD_KICK_BIT]))
    begin
      s_d.wdt_cnt = 32'h0000_0000;
    end
    else if (s_q.wdt_cnt == 32'(WDT_CLKS - 1))
    begin
      s_d.wdt_cnt = 32'h0000_0000;
      s_d.wdt_exp = 1'b1;
    end
    else
    begin
      s_d.wdt_cnt = s_q.wdt_cnt + 32'h0000_0001;
    end
    // core reset abandons any access in flight
    if (link.core_rst)
    begin
      s_d.busy = 1'b0;
      s_d.strobe = 1'b0;
      s_d.done = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s_q <= CORE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // apb: zero wait states, error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (paddr == ISPMC_STAT_OFS)
    begin
      prdata[7:0] = s_q.rdata;
      prdata[ISPMC_STAT_BUSY_BIT] = s_q.busy;
      prdata[ISPMC_STAT_HALT_BIT] = link.core_halt;
      prdata[ISPMC_STAT_RST_BIT] = link.core_rst;
      prdata[ISPMC_STAT_DROP_BIT] = s_q.dropped;
    end
    else if (paddr == ISPMC_CFG_OFS)
    begin
      prdata[3:0] = s_q.cfg;
    end
  end

  // drive the link
  assign link.sfr_addr = s_q.addr;
  assign link.sfr_wdata = s_q.wdata;
  assign link.sfr_wr = s_q.strobe && !s_q.is_read;
  assign link.sfr_rd = s_q.strobe && s_q.is_read;
  assign link.instr_done = s_q.done;
  assign link.int_pend = irq_i && s_q.cfg[ISPMC_CFG_IRQ_BIT];
  assign link.wdt_expire = s_q.wdt_exp;
  assign link.mcd_expire = mcd_fault_i && s_q.cfg[ISPMC_CFG_MCD_BIT];
  assign link.ext_rst = ext_rst_i;
  assign link.one_shot_en = !s_q.cfg[ISPMC_CFG_BYPASS_BIT];

endmodule // ispmc_core_end
`default_nettype wire

/* File: rtl/ispmc_dev_end.sv */
// Added by the designer: the device-side power mode controller and its registers.
`timescale 1ns/1ps
`default_nettype none
module ispmc_dev_end
  import ispmc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  ispmc_if.dev link,
  input wire logic cs_event_i,
  input wire logic suspend_req_i,
  input wire logic lp_osc_req_i,
  output logic suspend_o,
  output logic lp_osc_run_o,
  output logic prec_osc_en_o,
  output logic periph_clk_en_o,
  output logic low_power_o,
  output logic [1:0] mode_o
);

  localparam logic [2:0] RST_SEQ_LAST = 3'(ISPMC_RST_SEQ_CLKS - 1);
  localparam logic [1:0] SUSP_UPD = 2'(ISPMC_SUSP_UPD_CLKS);

  typedef struct packed {
    ispmc_mode_t mode;
    logic [1:0] pwr_ctrl;
    logic cs_wake_en;
    logic cs_wake_flag;
    logic suspend;
    logic [1:0] upd_cnt;
    logic [2:0] rst_cnt;
    logic [7:0] rdata;
    logic int_service;
  } ispmc_dev_state_t;

  localparam ispmc_dev_state_t DEV_RST = '{
    mode: ISPMC_MODE_RSTSEQ,
    pwr_ctrl: ISPMC_PWR_CTRL_RST,
    cs_wake_en: ISPMC_CS_WAKE_RST,
    cs_wake_flag: 1'b0,
    suspend: 1'b0,
    upd_cnt: 2'h0,
    rst_cnt: 3'h0,
    rdata: 8'h00,
    int_service: 1'b0
  };

  ispmc_dev_state_t s_q;
  ispmc_dev_state_t s_d;

  logic any_rst;
  logic halted;
  logic wr_pwr;
  logic wr_wake;
  logic rd_pwr;
  logic rd_wake;

  // all resets: external reset, watchdog and missing clock all count as reset
  assign any_rst = link.wdt_expire | link.mcd_expire | link.ext_rst;
  assign halted = (s_q.mode == ISPMC_MODE_IDLE) ||
                  (s_q.mode == ISPMC_MODE_STOP);
  // the core is halted in low power, so its write strobes are ignored there
  assign wr_pwr = link.sfr_wr && !halted &&
                  (link.sfr_addr == ISPMC_PWR_CTRL_ADDR);
  assign wr_wake = link.sfr_wr && !halted &&
                   (link.sfr_addr == ISPMC_WAKE_FLAGS_ADDR);
  assign rd_pwr = link.sfr_rd && (link.sfr_addr == ISPMC_PWR_CTRL_ADDR);
  assign rd_wake = link.sfr_rd && (link.sfr_addr == ISPMC_WAKE_FLAGS_ADDR);

  // next state of the whole block
  always_comb
  begin
    s_d = s_q;
    s_d.int_service = 1'b0;
    if (s_q.upd_cnt != 2'h0)
    begin
      s_d.upd_cnt = s_q.upd_cnt - 2'h1;
    end
    // register writes from the running core
    if (wr_pwr)
    begin
      s_d.pwr_ctrl[ISPMC_IDLE_BIT] = link.sfr_wdata[ISPMC_IDLE_BIT];
      s_d.pwr_ctrl[ISPMC_STOP_BIT] = link.sfr_wdata[ISPMC_STOP_BIT];
    end
    if (wr_wake)
    begin
      s_d.cs_wake_en = link.sfr_wdata[ISPMC_CS_WAKE_BIT];
      // writing zero also clears the flag, which is how wake is cleared
      if (!link.sfr_wdata[ISPMC_CS_WAKE_BIT])
      begin
        s_d.cs_wake_flag = 1'b0;
      end
    end
    // suspend entry and wake; a set flag blocks entry
    if (s_q.suspend)
    begin
      if (cs_event_i && s_q.cs_wake_en)
      begin
        s_d.cs_wake_flag = 1'b1;
        s_d.suspend = 1'b0;
        s_d.upd_cnt = SUSP_UPD;
      end
      else if (!suspend_req_i)
      begin
        s_d.suspend = 1'b0;
        s_d.upd_cnt = SUSP_UPD;
      end
    end
    else if (suspend_req_i && !s_q.cs_wake_flag &&
             s_q.mode == ISPMC_MODE_RUN)
    begin
      s_d.suspend = 1'b1;
    end
    // mode sequencing
    case (s_q.mode)
      ISPMC_MODE_RUN:
      begin
        // entry only when the setting instruction retires
        if (link.instr_done && s_d.pwr_ctrl[ISPMC_STOP_BIT])
        begin
          s_d.mode = ISPMC_MODE_STOP;
        end
        else if (link.instr_done && s_d.pwr_ctrl[ISPMC_IDLE_BIT])
        begin
          s_d.mode = ISPMC_MODE_IDLE;
        end
      end
      ISPMC_MODE_IDLE:
      begin
        if (link.int_pend)
        begin
          s_d.pwr_ctrl[ISPMC_IDLE_BIT] = 1'b0;
          s_d.int_service = 1'b1;
          s_d.mode = ISPMC_MODE_RUN;
        end
      end
      ISPMC_MODE_STOP:
      begin
        // interrupts are deliberately not looked at here
        s_d.mode = ISPMC_MODE_STOP;
      end
      default:
      begin
        if (s_q.rst_cnt == RST_SEQ_LAST)
        begin
          s_d.mode = ISPMC_MODE_RUN;
        end
        else
        begin
          s_d.rst_cnt = s_q.rst_cnt + 3'h1;
        end
      end
    endcase
    // read data is latched so the core sees a flop output
    if (rd_pwr)
    begin
      s_d.rdata = {6'h00, s_q.pwr_ctrl};
    end
    else if (rd_wake)
    begin
      // flags hidden while they settle after a suspend wake
      s_d.rdata = (s_q.upd_cnt != 2'h0) ? 8'h00 :
                  {7'h00, s_q.cs_wake_flag};
    end
    // a cap-sense event beats a software clear in the same cycle
    if (s_q.suspend && cs_event_i && s_q.cs_wake_en)
    begin
      s_d.cs_wake_flag = 1'b1;
    end
    // any reset ends every mode and restarts the sequence
    if (any_rst)
    begin
      s_d.mode = ISPMC_MODE_RSTSEQ;
      s_d.rst_cnt = 3'h0;
      s_d.pwr_ctrl = ISPMC_PWR_CTRL_RST;
      s_d.int_service = 1'b0;
    end
  end

  // single state register; wake flag survives internal resets
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s_q <= DEV_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // core control outputs
  assign link.sfr_rdata = s_q.rdata;
  assign link.core_halt = halted;
  assign link.int_service = s_q.int_service;
  assign link.core_rst = (s_q.mode == ISPMC_MODE_RSTSEQ);
  assign link.fetch_addr = ISPMC_RESET_VECTOR;

  // clocks and user-side status
  assign prec_osc_en_o = (s_q.mode != ISPMC_MODE_STOP);
  assign periph_clk_en_o = (s_q.mode != ISPMC_MODE_STOP);
  // low-power oscillator only forced on; stop leaves it alone
  assign lp_osc_run_o = lp_osc_req_i | s_q.cs_wake_flag;
  // true low power needs the one-shot active
  assign low_power_o = halted && link.one_shot_en;
  assign suspend_o = s_q.suspend;
  assign mode_o = s_q.mode;

endmodule // ispmc_dev_end
`default_nettype wire

/* File: rtl/ispmc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ispmc_if (
  input wire logic ref_clk_i
);
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_rdata;
  logic instr_done;
  logic int_pend;
  logic wdt_expire;
  logic mcd_expire;
  logic ext_rst;
  logic one_shot_en;
  logic core_halt;
  logic int_service;
  logic core_rst;
  logic [15:0] fetch_addr;

  modport dev (
    input sfr_addr, sfr_wdata, sfr_wr, sfr_rd, instr_done, int_pend,
    input wdt_expire, mcd_expire, ext_rst, one_shot_en,
    output sfr_rdata, core_halt, int_service, core_rst, fetch_addr
  );
  modport core (
    output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, instr_done, int_pend,
    output wdt_expire, mcd_expire, ext_rst, one_shot_en,
    input sfr_rdata, core_halt, int_service, core_rst, fetch_addr
  );
endinterface
`default_nettype wire

/* File: rtl/ispmc_pkg.sv */
package ispmc_pkg;

  // core-side register map of the power block
  localparam logic [7:0] ISPMC_PWR_CTRL_ADDR = 8'h8f;
  localparam logic [7:0] ISPMC_WAKE_FLAGS_ADDR = 8'hce;
  localparam int ISPMC_IDLE_BIT = 0;
  localparam int ISPMC_STOP_BIT = 1;
  localparam int ISPMC_CS_WAKE_BIT = 0;
  localparam logic [1:0] ISPMC_PWR_CTRL_RST = 2'h0;
  localparam logic ISPMC_CS_WAKE_RST = 1'b0;
  localparam logic [15:0] ISPMC_RESET_VECTOR = 16'h0000;

  // timing
  localparam int ISPMC_SYS_CLK_HZ = 10_000_000;
  localparam int ISPMC_SUSP_UPD_CLKS = 2;
  localparam int ISPMC_RST_SEQ_CLKS = 4;
  localparam int ISPMC_WDT_TIMEOUT_US = 1000;
  localparam int ISPMC_WDT_CLKS =
    ISPMC_WDT_TIMEOUT_US * (ISPMC_SYS_CLK_HZ / 1_000_000);

  // apb registers of the core end
  localparam logic [11:0] ISPMC_CMD_OFS = 12'h000;
  localparam logic [11:0] ISPMC_STAT_OFS = 12'h004;
  localparam logic [11:0] ISPMC_CFG_OFS = 12'h008;
  localparam int ISPMC_CMD_ADDR_LSB = 0;
  localparam int ISPMC_CMD_DATA_LSB = 8;
  localparam int ISPMC_CMD_READ_BIT = 16;
  localparam int ISPMC_CMD_KICK_BIT = 17;
  localparam int ISPMC_CMD_GO_BIT = 18;
  localparam int ISPMC_STAT_BUSY_BIT = 8;
  localparam int ISPMC_STAT_HALT_BIT = 9;
  localparam int ISPMC_STAT_RST_BIT = 10;
  localparam int ISPMC_STAT_DROP_BIT = 11;
  localparam int ISPMC_CFG_WDT_BIT = 0;
  localparam int ISPMC_CFG_MCD_BIT = 1;
  localparam int ISPMC_CFG_BYPASS_BIT = 2;
  localparam int ISPMC_CFG_IRQ_BIT = 3;
  localparam logic [3:0] ISPMC_CFG_RST = 4'h1;

  typedef enum logic [1:0] {
    ISPMC_MODE_RUN,
    ISPMC_MODE_IDLE,
    ISPMC_MODE_STOP,
    ISPMC_MODE_RSTSEQ
  } ispmc_mode_t;

endpackage
